/* File: common/flash_host_pkg.sv */
// constants, types and register map of the flash host controller
`default_nettype none
package flash_host_pkg;
    // ------------------------------------------------------------
    // clock and pin timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_NS = 5;
    localparam int unsigned GLITCH_NS = 3;
    localparam int unsigned T_WP_NS = 40;
    localparam int unsigned T_WPH_NS = 30;
    localparam int unsigned T_ACC_NS = 90;
    localparam int unsigned T_OEH_NS = 30;
    localparam int unsigned SYNC_LAT = 4;

    function automatic int unsigned ns_to_min_cyc(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int unsigned GLITCH_CYC = ns_to_min_cyc(GLITCH_NS);
    localparam int unsigned WP_CYC = (ns_to_min_cyc(T_WP_NS) > GLITCH_CYC) ? ns_to_min_cyc(T_WP_NS) : GLITCH_CYC + 1;
    localparam int unsigned WPH_CYC = ns_to_min_cyc(T_WPH_NS);
    localparam int unsigned RD_CYC = ns_to_min_cyc(T_ACC_NS) + SYNC_LAT;
    localparam int unsigned OEH_CYC = ns_to_min_cyc(T_OEH_NS);

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_STATUS = 5'h01;
    localparam logic [4:0] REG_MASK = 5'h02;
    localparam logic [4:0] REG_RDATA = 5'h03;
    localparam logic [4:0] REG_TARGET = 5'h04;
    localparam logic [4:0] REG_CYC_ADDR = 5'h08;
    localparam logic [4:0] REG_CYC_DATA = 5'h10;
    localparam int unsigned CYC_MAX = 6;

    localparam int unsigned CTRL_START = 0;
    localparam int unsigned CTRL_OP_LSB = 1;
    localparam int unsigned CTRL_PRE_RESET = 4;
    localparam int unsigned CTRL_RETRY = 5;
    localparam int unsigned CTRL_COUNT_LSB = 8;
    localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0000;
    localparam logic [2:0] MASK_RESET_VAL = 3'h0;

    localparam int unsigned ST_DONE = 0;
    localparam int unsigned ST_ABORT = 1;
    localparam int unsigned ST_TIMEOUT = 2;
    localparam int unsigned ST_BUSY = 8;
    localparam int unsigned ST_PROTECTED = 9;
    localparam int unsigned ST_READY = 10;
    localparam int unsigned ST_SUPPLY = 11;

    // ------------------------------------------------------------
    // flash command values
    // ------------------------------------------------------------
    localparam logic [15:0] RESET_CMD = 16'h00f0;
    localparam logic [20:0] RESET_ADDR = 21'h000000;
    localparam logic [7:0] PROTECT_ID = 8'h01;
    localparam logic [2:0] PROTECT_ID_BITS = 3'h2;

    typedef enum logic [2:0] {
        OP_SEQ = 3'h0,
        OP_SEQ_POLL = 3'h1,
        OP_READ = 3'h2,
        OP_PROTECT = 3'h3
    } op_e;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic [20:0] addr;
    } flash_pins_s;
endpackage
`default_nettype wire

/* File: verilog/pin_sync.sv */
// three-stage synchroniser that passes a change once stages two and three agree
`default_nettype none
module pin_sync #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // pin side
    input wire logic [W-1:0] pin_i,
    // clock side
    output logic [W-1:0] sync_o
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    wire logic [W-1:0] agree = ~(s2 ^ s3);

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
            sync_o <= INIT;
        end else begin
            s1 <= pin_i;
            s2 <= s1;
            s3 <= s2;
            sync_o <= (agree & s3) | (~agree & sync_o);
        end
    end
endmodule
`default_nettype wire

/* File: verilog/flash_host_ctrl.sv */
// host controller that issues command, read, poll and protect-check cycles to a parallel flash
//
// The address map and the strobed register port were chosen for this implementation.
`default_nettype none
module flash_host_ctrl #(
    parameter int unsigned POLL_LIMIT = 100000
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // software register port
    input wire logic [4:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic irq_o,
    // flash strobes and address
    output flash_host_pkg::flash_pins_s flash_o,
    // flash data bus
    output logic [15:0] dq_o,
    output logic dq_oe_n_o,
    input wire logic [15:0] dq_i,
    // flash status pins
    input wire logic ready_busy_n_i,
    input wire logic supply_ok_i
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [15:0] dq_sync;
    logic [1:0] st_sync;
    wire logic sup_ok = st_sync[1];
    wire logic rb_ready = st_sync[0];

    pin_sync #(.W(16), .INIT(16'h0000)) u_dq_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .pin_i(dq_i),
        .sync_o(dq_sync)
    );
    pin_sync #(.W(2), .INIT(2'h0)) u_st_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .pin_i({supply_ok_i, ready_busy_n_i}),
        .sync_o(st_sync)
    );

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    logic [31:0] ctrl;
    logic [2:0] mask;
    logic [2:0] sticky;
    logic [15:0] rdata;
    logic [20:0] target;
    logic [20:0] cyc_addr [flash_host_pkg::CYC_MAX];
    logic [15:0] cyc_data [flash_host_pkg::CYC_MAX];
    logic start;
    logic prot;

    wire logic wr_ctrl = reg_wr_i && reg_addr_i == flash_host_pkg::REG_CTRL;
    wire logic wr_mask = reg_wr_i && reg_addr_i == flash_host_pkg::REG_MASK;
    wire logic wr_target = reg_wr_i && reg_addr_i == flash_host_pkg::REG_TARGET;
    wire logic rd_status = reg_rd_i && reg_addr_i == flash_host_pkg::REG_STATUS;
    wire logic cyc_hit = reg_addr_i[2:0] < 3'(flash_host_pkg::CYC_MAX);
    wire logic wr_caddr = reg_wr_i && reg_addr_i[4:3] == flash_host_pkg::REG_CYC_ADDR[4:3] && cyc_hit;
    wire logic wr_cdata = reg_wr_i && reg_addr_i[4:3] == flash_host_pkg::REG_CYC_DATA[4:3] && cyc_hit;

    wire flash_host_pkg::op_e op = flash_host_pkg::op_e'(ctrl[flash_host_pkg::CTRL_OP_LSB +: 3]);
    wire logic pre_reset = ctrl[flash_host_pkg::CTRL_PRE_RESET];
    wire logic retry_en = ctrl[flash_host_pkg::CTRL_RETRY];
    wire logic [2:0] cyc_count = ctrl[flash_host_pkg::CTRL_COUNT_LSB +: 3];
    wire logic is_write_op = op == flash_host_pkg::OP_SEQ || op == flash_host_pkg::OP_SEQ_POLL;

    // ------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_WR_LOW = 3'b001,
        S_WR_HIGH = 3'b011,
        S_RD_LOW = 3'b010,
        S_RD_HIGH = 3'b110,
        S_WAIT_SUP = 3'b100
    } state_e;

    state_e state, next_state;
    logic [7:0] cnt, next_cnt;
    logic [2:0] idx, next_idx;
    logic in_reset, next_in_reset;
    logic first_read, next_first_read;
    logic last_toggle, next_last_toggle;
    logic retry_pending, next_retry_pending;
    logic [31:0] poll_cnt, next_poll_cnt;
    logic [15:0] sample, next_sample;
    logic [15:0] next_rdata;
    logic next_prot;
    logic ev_done, ev_abort, ev_timeout;
    logic launch;
    flash_host_pkg::flash_pins_s next_pins;
    logic [15:0] next_dq;

    wire logic busy = state != S_IDLE;
    wire logic in_flight = state inside {S_WR_LOW, S_WR_HIGH, S_RD_LOW, S_RD_HIGH};
    // protect check uses the block address with the identification bits forced
    wire logic [20:0] prot_addr = {target[20:7], 1'b0, target[5:2], flash_host_pkg::PROTECT_ID_BITS[1:0]};
    // polling reads the address inside the block being erased or programmed
    wire logic [20:0] rd_addr = (op == flash_host_pkg::OP_PROTECT) ? prot_addr : target;
    wire logic cnt_zero = cnt == 8'h00;
    wire logic last_cyc = idx == cyc_count - 3'h1;

    assign launch = (state == S_IDLE && start && sup_ok) || (state == S_WAIT_SUP && sup_ok && retry_pending);

    always_comb begin
        next_state = state;
        next_cnt = cnt_zero ? cnt : cnt - 8'h01;
        next_idx = idx;
        next_in_reset = in_reset;
        next_first_read = first_read;
        next_last_toggle = last_toggle;
        next_retry_pending = retry_pending;
        next_poll_cnt = poll_cnt;
        next_sample = sample;
        next_rdata = rdata;
        next_prot = prot;
        ev_done = 1'b0;
        ev_abort = 1'b0;
        ev_timeout = 1'b0;
        unique case (state)
            S_IDLE: begin
                if (start && !sup_ok) begin
                    next_state = S_WAIT_SUP;
                    next_retry_pending = 1'b1;
                end
            end
            S_WR_LOW: begin
                if (cnt_zero) begin
                    next_state = S_WR_HIGH;
                    next_cnt = 8'(flash_host_pkg::WPH_CYC - 1);
                end
            end
            S_WR_HIGH: begin
                if (cnt_zero) begin
                    if (in_reset) begin
                        next_in_reset = 1'b0;
                        next_idx = 3'h0;
                        next_state = S_WR_LOW;
                        next_cnt = 8'(flash_host_pkg::WP_CYC - 1);
                    end else if (!last_cyc) begin
                        next_idx = idx + 3'h1;
                        next_state = S_WR_LOW;
                        next_cnt = 8'(flash_host_pkg::WP_CYC - 1);
                    end else if (op == flash_host_pkg::OP_SEQ_POLL) begin
                        next_state = S_RD_LOW;
                        next_cnt = 8'(flash_host_pkg::RD_CYC - 1);
                        next_first_read = 1'b1;
                        next_poll_cnt = 32'h0;
                    end else begin
                        next_state = S_IDLE;
                        ev_done = 1'b1;
                    end
                end
            end
            S_RD_LOW: begin
                if (cnt_zero) begin
                    next_state = S_RD_HIGH;
                    next_cnt = 8'(flash_host_pkg::OEH_CYC - 1);
                    next_sample = dq_sync;
                end
            end
            S_RD_HIGH: begin
                if (cnt_zero) begin
                    next_rdata = sample;
                    if (op == flash_host_pkg::OP_SEQ_POLL && (first_read || sample[6] != last_toggle)) begin
                        next_last_toggle = sample[6];
                        next_first_read = 1'b0;
                        next_poll_cnt = poll_cnt + 32'h1;
                        if (poll_cnt == 32'(POLL_LIMIT - 1)) begin
                            next_state = S_IDLE;
                            ev_timeout = 1'b1;
                        end else begin
                            next_state = S_RD_LOW;
                            next_cnt = 8'(flash_host_pkg::RD_CYC - 1);
                        end
                    end else begin
                        next_prot = (op == flash_host_pkg::OP_PROTECT) ? sample[7:0] == flash_host_pkg::PROTECT_ID : prot;
                        next_state = S_IDLE;
                        ev_done = 1'b1;
                    end
                end
            end
            S_WAIT_SUP: begin
                if (sup_ok && !retry_pending) begin
                    next_state = S_IDLE;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
        // supply lockout kills the operation; restart only with the whole sequence
        if (in_flight && !sup_ok) begin
            next_state = S_WAIT_SUP;
            next_retry_pending = retry_en && is_write_op;
            ev_abort = 1'b1;
        end
        if (launch) begin
            next_retry_pending = 1'b0;
            next_idx = 3'h0;
            next_first_read = 1'b1;
            next_poll_cnt = 32'h0;
            if (!is_write_op) begin
                next_state = S_RD_LOW;
                next_cnt = 8'(flash_host_pkg::RD_CYC - 1);
                next_in_reset = 1'b0;
            end else begin
                next_state = S_WR_LOW;
                next_cnt = 8'(flash_host_pkg::WP_CYC - 1);
                next_in_reset = pre_reset;
            end
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    always_comb begin
        next_pins.we_n = next_state != S_WR_LOW;
        next_pins.oe_n = next_state != S_RD_LOW;
        next_pins.ce_n = !(next_state inside {S_WR_LOW, S_RD_LOW});
        if (next_state inside {S_RD_LOW, S_RD_HIGH}) begin
            next_pins.addr = rd_addr;
        end else if (next_in_reset) begin
            next_pins.addr = flash_host_pkg::RESET_ADDR;
        end else begin
            next_pins.addr = cyc_addr[next_idx];
        end
        next_dq = next_in_reset ? flash_host_pkg::RESET_CMD : cyc_data[next_idx];
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state <= S_IDLE;
            cnt <= 8'h00;
            idx <= 3'h0;
            in_reset <= 1'b0;
            first_read <= 1'b0;
            last_toggle <= 1'b0;
            retry_pending <= 1'b0;
            poll_cnt <= 32'h0;
            sample <= 16'h0000;
            flash_o <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 21'h000000};
            dq_o <= 16'h0000;
            dq_oe_n_o <= 1'b1;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            idx <= next_idx;
            in_reset <= next_in_reset;
            first_read <= next_first_read;
            last_toggle <= next_last_toggle;
            retry_pending <= next_retry_pending;
            poll_cnt <= next_poll_cnt;
            sample <= next_sample;
            flash_o <= next_pins;
            dq_o <= next_dq;
            dq_oe_n_o <= !(next_state inside {S_WR_LOW, S_WR_HIGH});
        end
    end

    // ------------------------------------------------------------
    // register file, status and interrupt
    // ------------------------------------------------------------
    wire logic [2:0] events = {ev_timeout, ev_abort, ev_done};
    wire logic [31:0] status_word = {20'h0, sup_ok, rb_ready, prot, busy, 5'h0, sticky};
    logic [31:0] next_reg_rdata;

    always_comb begin
        next_reg_rdata = 32'h0000_0000;
        if (reg_addr_i == flash_host_pkg::REG_CTRL) begin
            next_reg_rdata = ctrl & ~32'h0000_0001;
        end else if (reg_addr_i == flash_host_pkg::REG_STATUS) begin
            next_reg_rdata = status_word;
        end else if (reg_addr_i == flash_host_pkg::REG_MASK) begin
            next_reg_rdata = {29'h0, mask};
        end else if (reg_addr_i == flash_host_pkg::REG_RDATA) begin
            next_reg_rdata = {16'h0, rdata};
        end else if (reg_addr_i == flash_host_pkg::REG_TARGET) begin
            next_reg_rdata = {11'h0, target};
        end else if (reg_addr_i[4:3] == flash_host_pkg::REG_CYC_ADDR[4:3] && cyc_hit) begin
            next_reg_rdata = {11'h0, cyc_addr[reg_addr_i[2:0]]};
        end else if (reg_addr_i[4:3] == flash_host_pkg::REG_CYC_DATA[4:3] && cyc_hit) begin
            next_reg_rdata = {16'h0, cyc_data[reg_addr_i[2:0]]};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ctrl <= flash_host_pkg::CTRL_RESET_VAL;
            mask <= flash_host_pkg::MASK_RESET_VAL;
            sticky <= 3'h0;
            rdata <= 16'h0000;
            target <= 21'h000000;
            start <= 1'b0;
            prot <= 1'b0;
            reg_rdata_o <= 32'h0000_0000;
            for (int i = 0; i < flash_host_pkg::CYC_MAX; i++) begin
                cyc_addr[i] <= 21'h000000;
                cyc_data[i] <= 16'h0000;
            end
        end else begin
            if (wr_ctrl && !busy) begin
                ctrl <= reg_wdata_i;
            end
            start <= wr_ctrl && !busy && reg_wdata_i[flash_host_pkg::CTRL_START];
            if (wr_mask) begin
                mask <= reg_wdata_i[2:0];
            end
            if (wr_target && !busy) begin
                target <= reg_wdata_i[20:0];
            end
            if (wr_caddr && !busy) begin
                cyc_addr[reg_addr_i[2:0]] <= reg_wdata_i[20:0];
            end
            if (wr_cdata && !busy) begin
                cyc_data[reg_addr_i[2:0]] <= reg_wdata_i[15:0];
            end
            sticky <= (sticky & ~{3{rd_status}}) | events;
            rdata <= next_rdata;
            prot <= next_prot;
            reg_rdata_o <= reg_rd_i ? next_reg_rdata : 32'h0000_0000;
        end
    end

    assign irq_o = |(sticky & mask);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_start_pre;
        state == S_IDLE && start && sup_ok && pre_reset && is_write_op;
    endsequence
    sequence s_reset_cycle;
        !flash_o.we_n && !flash_o.ce_n && !dq_oe_n_o && dq_o == flash_host_pkg::RESET_CMD;
    endsequence
    sequence s_recover;
        state == S_WAIT_SUP && sup_ok && retry_pending;
    endsequence
    sequence s_first_write;
        !flash_o.we_n && (in_reset || idx == 3'h0);
    endsequence

    a_pre_reset_first: assert property (s_start_pre |=> s_reset_cycle)
        else $error("reset command not issued first");
    a_retry_full_seq: assert property (s_recover |=> s_first_write)
        else $error("retry did not restart at first cycle");
    a_abort_release: assert property (in_flight && !sup_ok |=> flash_o.we_n && flash_o.oe_n ##1 state == S_WAIT_SUP
        || state == S_IDLE)
        else $error("strobes not released after abort");
    a_read_we_high: assert property (!flash_o.oe_n |-> flash_o.we_n && dq_oe_n_o)
        else $error("write enable low or bus driven during read");
    a_protect_addr: assert property (!flash_o.oe_n && op == flash_host_pkg::OP_PROTECT |->
        !flash_o.addr[6] && flash_o.addr[1] && !flash_o.addr[0] && flash_o.addr[20:7] == target[20:7])
        else $error("protect check address bits wrong");
    a_poll_target: assert property (!flash_o.oe_n && op == flash_host_pkg::OP_SEQ_POLL |->
        flash_o.addr == target)
        else $error("poll read outside target address");
endmodule
`default_nettype wire

/* File: bench/flash_dev_model.sv */
// behavioural flash device answering the host controller
`default_nettype none
module flash_dev_model #(
    parameter int unsigned BUSY_READS = 3
) (
    // strobes and data from the host
    input wire flash_host_pkg::flash_pins_s pins_i,
    input wire logic [15:0] dq_i,
    input wire logic supply_ok_i,
    // data and status to the host
    output logic [15:0] dq_o,
    output logic ready_busy_n_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int unsigned n_wr = 0;
    int unsigned seq_len = 0;
    int unsigned busy_len = BUSY_READS;
    int unsigned busy = 0;
    logic [15:0] last_data = 16'h0000;
    logic [15:0] held = 16'h0000;
    logic tog = 1'b0;
    logic armed = 1'b0;
    // far future until a first command window opens, so the power-up edge is no pulse
    realtime t_low = 1.0e9;
    // a command cycle lasts while write enable and chip enable are both low
    wire logic sel_wr = !pins_i.we_n && !pins_i.ce_n;
    always @(pins_i) begin
        if (pins_i.we_n && pins_i.ce_n && pins_i.oe_n) begin
            armed = 1'b1;
        end
    end
    always @(posedge sel_wr) t_low = $realtime;
    always @(negedge sel_wr) begin
        if (armed && supply_ok_i && $realtime - t_low >= 3.0) begin
            n_wr++;
            last_data = dq_i;
            seq_len = (dq_i[7:0] == 8'hf0) ? 0 : seq_len + 1;
            busy = (dq_i[7:0] == 8'hf0) ? 0 : busy_len;
        end
    end
    always @(negedge supply_ok_i) busy = 0;
    assign ready_busy_n_o = (busy == 0);
    always @(negedge pins_i.oe_n) begin
        if (!pins_i.ce_n) begin
            if (busy != 0) begin
                tog = ~tog;
                held = {held[15:7], tog, held[5:0]};
                busy--;
            end else if (!pins_i.addr[6] && pins_i.addr[1:0] == 2'b10) begin
                held = 16'h0001;
            end else begin
                held = pins_i.addr[15:0] ^ 16'h5a3c;
            end
        end
    end
    // released bus shows the inverse of the last value
    assign dq_o = (!pins_i.oe_n && !pins_i.ce_n) ? held : ~held;
endmodule
`default_nettype wire

/* File: bench/flash_command_write_protection_tb_top.sv */
// self-checking bench of the flash host controller
`default_nettype none
module flash_command_write_protection_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [4:0] reg_addr_i = 5'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic supply_ok_i = 1'b1;
    logic [31:0] reg_rdata_o;
    logic [31:0] st;
    logic irq_o;
    logic dq_oe_n_o;
    logic rb_n;
    logic [15:0] dq_o;
    logic [15:0] dev_dq;
    logic [15:0] dq_bus;
    flash_host_pkg::flash_pins_s flash_o;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;
    int w0;
    assign dq_bus = dq_oe_n_o ? dev_dq : dq_o;
    flash_host_ctrl #(.POLL_LIMIT(8)) dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .irq_o(irq_o), .flash_o(flash_o), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .dq_i(dq_bus),
        .ready_busy_n_i(rb_n), .supply_ok_i(supply_ok_i));
    flash_dev_model model_u (.pins_i(flash_o), .dq_i(dq_bus), .supply_ok_i(supply_ok_i), .dq_o(dev_dq),
        .ready_busy_n_o(rb_n));
    initial forever #2.5 clk_sys_i = ~clk_sys_i;
    task automatic wrap_up();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    // start an operation and wait for its interrupt
    task automatic go(input logic [31:0] ctrl, input logic [20:0] tgt, input logic [2:0] msk);
        rd(5'h01, st);
        wr(5'h04, {11'h0, tgt});
        wr(5'h02, {29'h0, msk});
        wr(5'h00, ctrl | 32'h1);
        for (int n = 0; n < 600 && irq_o !== 1'b1; n++) @(posedge clk_sys_i);
    endtask
    task automatic t_reset();
        rd(5'h00, st);
        check("ctrl", st, 32'h0);
        rd(5'h02, st);
        check("mask", st, 32'h0);
        wr(5'h1f, 32'hffff_ffff);
        rd(5'h1f, st);
        check("unmapped", st, 32'h0);
        check("strobes", {flash_o.ce_n, flash_o.oe_n, flash_o.we_n}, 3'h7);
    endtask
    task automatic t_seq();
        w0 = model_u.n_wr;
        for (int i = 0; i < 3; i++) begin
            wr(5'h08 + 5'(i), 32'h555 + i);
            wr(5'h10 + 5'(i), 32'ha0 + i);
        end
        go(32'h0310, 21'h0, 3'h0);
        check("irq masked", irq_o, 1'b0);
        wr(5'h02, 32'h1);
        #1 check("irq", irq_o, 1'b1);
        rd(5'h01, st);
        check("seq status", st[2:0], 3'h1);
        check("irq clear", irq_o, 1'b0);
        check("writes", model_u.n_wr - w0, 4);
        check("held cycles", model_u.seq_len, 3);
        check("last data", model_u.last_data, 16'h00a2);
    endtask
    task automatic t_poll();
        wr(5'h08, 32'h555);
        wr(5'h10, 32'ha0);
        go(32'h0102, 21'h012345, 3'h7);
        rd(5'h01, st);
        check("poll status", st[2:0], 3'h1);
        check("ready supply", st[11:10], 2'h3);
        rd(5'h03, st);
        check("poll data", st[15:0], 16'h7979);
        check("busy left", model_u.busy, 0);
    endtask
    task automatic t_timeout();
        model_u.busy_len = 12;
        go(32'h0102, 21'h012345, 3'h7);
        rd(5'h01, st);
        check("timeout", st[2:0], 3'h4);
        model_u.busy_len = 3;
        model_u.busy = 0;
    endtask
    task automatic t_rdp();
        go(32'h0104, 21'h012345, 3'h7);
        rd(5'h03, st);
        check("read data", st[15:0], 16'h7979);
        go(32'h0106, 21'h012345, 3'h7);
        rd(5'h01, st);
        check("protected", {st[9], st[0]}, 2'h3);
    endtask
    task automatic t_abort();
        w0 = model_u.n_wr;
        wr(5'h00, 32'h0101);
        for (int n = 0; n < 20 && flash_o.we_n !== 1'b0; n++) @(posedge clk_sys_i);
        supply_ok_i <= 1'b0;
        for (int n = 0; n < 100 && irq_o !== 1'b1; n++) @(posedge clk_sys_i);
        rd(5'h01, st);
        check("abort", st[1:0], 2'h2);
        supply_ok_i <= 1'b1;
        repeat (100) @(posedge clk_sys_i);
        check("no restart", model_u.n_wr, w0);
        wr(5'h00, 32'h0121);
        for (int n = 0; n < 20 && flash_o.we_n !== 1'b0; n++) @(posedge clk_sys_i);
        supply_ok_i <= 1'b0;
        repeat (20) @(posedge clk_sys_i);
        supply_ok_i <= 1'b1;
        repeat (100) @(posedge clk_sys_i);
        rd(5'h01, st);
        check("retry status", st[1:0], 2'h3);
        check("retry writes", model_u.n_wr - w0, 1);
    endtask
    initial begin
        repeat (8) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
        t_reset();
        t_seq();
        t_poll();
        t_timeout();
        t_rdp();
        t_abort();
        wrap_up();
    end
endmodule
`default_nettype wire
